// >>> include/tpr_pkg.sv
// Constants, types and helper functions of the three-port memory block.
// Assumes one fast system clock that samples all port pins and port clocks.
//
// Overview of operation
// - Width select: 0 gives 128 deep, 1 gives 64
// - Seven-bit address; wide mode ignores bit zero
// - Read data is placed in low bits
// - Read port deselected reads back all zeros
// - Write port deselected performs no write
// - Active-high write enable qualifies each write
// - Write inputs captured at write clock rise
// - Global clear empties read-side registers at once
// - Read registers load on enabled edge, clear low
// - Bypassed read register passes input straight through
// - Correction enable and pipelined or direct correction
// - Single-bit corrected flag per read port
// - Double-bit detected flag per read port
// - Hardening enable votes triplicated write command registers
// - Lock blocks the internal system interface
// - Busy shows internal system interface access
// - Same-word read and write: undefined read, good write
// - Both read ports may share one address

package tpr_pkg;

   // =========================================================
   // Geometry
   localparam int ADDR_W    = 7;
   localparam int DATA_W    = 18;
   localparam int ENTRY_W   = 12;
   localparam int NARROW_W  = 9;
   localparam int DEPTH     = 128;
   localparam int CHK_W     = 6;
   localparam int PAR_W     = 5;
   localparam int HAM_LEN   = 24;
   localparam int SEL_W     = 2;
   localparam int RD_PORTS  = 2;
   localparam int VOTE_N    = 3;
   localparam int CHK_HALF  = 3;

   localparam logic [SEL_W-1:0] SEL_ALL     = 2'h3;
   localparam logic             WIDTH_DEEP  = 1'h0;
   localparam logic             WIDTH_WIDE  = 1'h1;
   localparam logic             HALF_LOW    = 1'h0;
   localparam logic             HALF_HIGH   = 1'h1;

   // =========================================================
   // Carriers
   typedef struct packed {
      logic              clk;
      logic [ADDR_W-1:0] addr;
      logic [SEL_W-1:0]  select;
      logic              addr_en;
      logic              addr_sync_clear_n;
      logic              pipe_en;
      logic              pipe_sync_clear_n;
   } tpr_rd_in_t;

   typedef struct packed {
      logic              clk;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] din;
      logic [SEL_W-1:0]  select;
      logic              wen;
   } tpr_wr_in_t;

   typedef struct packed {
      logic              rd0_width;
      logic              rd1_width;
      logic              wr_width;
      logic              twelve_bit_mode;
      logic              rd0_addr_bypass;
      logic              rd0_pipe_bypass;
      logic              rd1_addr_bypass;
      logic              rd1_pipe_bypass;
      logic              ecc_enable;
      logic              correction_pipe_skip;
      logic              transient_harden_enable;
      logic              system_access_lock;
   } tpr_cfg_t;

   typedef struct packed {
      logic               req;
      logic               we;
      logic [ADDR_W-1:0]  addr;
      logic [ENTRY_W-1:0] wdata;
   } tpr_sys_in_t;

   typedef struct packed {
      logic              double_found;
      logic              single_fixed;
      logic [DATA_W-1:0] data;
   } tpr_rd_out_t;

   typedef struct packed {
      logic              go;
      logic              wide;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] din;
   } tpr_wr_cmd_t;

   // =========================================================
   // Single-error-correct, double-error-detect code
   function automatic logic [CHK_W-1:0] tpr_ecc_check(input logic [DATA_W-1:0] d);
      logic [HAM_LEN-1:0] code;
      logic [PAR_W-1:0]   p;
      int                 j;
      code = '0;
      p    = '0;
      j    = 0;
      for (int pos = 1; pos < HAM_LEN; pos++)
      begin
         if ((pos & (pos - 1)) != 0)
         begin
            code[pos] = d[j];
            j++;
         end
      end
      for (int k = 0; k < PAR_W; k++)
      begin
         for (int pos = 1; pos < HAM_LEN; pos++)
         begin
            if (pos[k])
            begin
               p[k] = p[k] ^ code[pos];
            end
         end
      end
      return {(^d) ^ (^p), p};
   endfunction : tpr_ecc_check

   function automatic tpr_rd_out_t tpr_ecc_fix(input logic [DATA_W-1:0] d,
                                               input logic [CHK_W-1:0]  chk);
      tpr_rd_out_t      r;
      logic [PAR_W-1:0] syn;
      logic [CHK_W-1:0] full;
      logic             ov_err;
      int               j;
      r      = '{double_found: 1'b0, single_fixed: 1'b0, data: d};
      full   = tpr_ecc_check(d);
      syn    = full[PAR_W-1:0] ^ chk[PAR_W-1:0];
      ov_err = (^d) ^ (^chk);
      j      = 0;
      if (ov_err)
      begin
         r.single_fixed = 1'b1;
         for (int pos = 1; pos < HAM_LEN; pos++)
         begin
            if ((pos & (pos - 1)) != 0)
            begin
               if (syn == pos[PAR_W-1:0])
               begin
                  r.data[j] = ~d[j];
               end
               j++;
            end
         end
      end
      else if (syn != '0)
      begin
         r.double_found = 1'b1;
      end
      return r;
   endfunction : tpr_ecc_fix

   function automatic logic tpr_vote(input logic a, input logic b, input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction : tpr_vote

endpackage : tpr_pkg

// >>> logic/tpr_rd_reg.sv
// Read-side register with enable, synchronous clear and bypass.
// Assumes tick is a one-cycle pulse marking the port clock's rising edge.
`timescale 1ns/1ps

module tpr_rd_reg
   import tpr_pkg::*;
#(
   parameter int W = DATA_W
)
(
   input  wire logic         clk,
   input  wire logic         arst,
   input  wire logic         tick,
   input  wire logic         bypass,
   input  wire logic         en,
   input  wire logic         sync_clear_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] hold_q;

   // =========================================================
   // Storage
   always_ff @(posedge clk or posedge arst)
   begin
      if (arst)
      begin
         hold_q <= '0;
      end
      else if (tick && en)
      begin
         hold_q <= sync_clear_n ? d : '0;
      end
   end

   assign q = bypass ? d : hold_q;

endmodule : tpr_rd_reg

// >>> logic/tpr_three_port_mem.sv
// Three-port memory: one write port, two read ports, optional correction.
// Assumes port clocks and port pins are slow against clk and are sampled.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps

module tpr_three_port_mem
   import tpr_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               global_async_clear_n,
   input  wire tpr_rd_in_t         rd0_in,
   input  wire tpr_rd_in_t         rd1_in,
   input  wire tpr_wr_in_t         wr_in,
   input  wire tpr_cfg_t           cfg,
   input  wire tpr_sys_in_t        sys_in,
   output tpr_rd_out_t             rd0_out,
   output tpr_rd_out_t             rd1_out,
   output logic [ENTRY_W-1:0]      sys_rdata,
   output logic                    busy
);

   // =========================================================
   // Declarations
   logic               rd_arst;
   tpr_rd_in_t         rd_s1_q   [RD_PORTS];
   tpr_rd_in_t         rd_s2_q   [RD_PORTS];
   logic               rd_clk_prev_q [RD_PORTS];
   logic               rd_tick   [RD_PORTS];
   tpr_rd_in_t         rd_pin    [RD_PORTS];
   tpr_wr_in_t         wr_s1_q;
   tpr_wr_in_t         wr_s2_q;
   logic               wr_clk_prev_q;
   logic               wr_tick;
   tpr_cfg_t           cfg_s1_q;
   tpr_cfg_t           cfg_s2_q;
   tpr_wr_cmd_t        wr_cmd_q  [VOTE_N];
   tpr_wr_cmd_t        wr_cmd;
   logic [ENTRY_W-1:0] mem       [DEPTH];
   logic               sys_take;
   logic               sys_rd_take;
   logic               busy_q;
   logic [ENTRY_W-1:0] sys_rdata_q;
   tpr_rd_out_t        out_q     [RD_PORTS];
   logic [CHK_W-1:0]   wr_chk;

   // Either the system reset or the global clear empties the read side
   assign rd_arst = reset | ~global_async_clear_n;

   assign rd_pin[0] = rd0_in;
   assign rd_pin[1] = rd1_in;

   // =========================================================
   // Pin synchronisers and port clock edge detection
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < RD_PORTS; i++)
         begin
            rd_s1_q[i]       <= '0;
            rd_s2_q[i]       <= '0;
            rd_clk_prev_q[i] <= 1'b0;
         end
      end
      else
      begin
         for (int i = 0; i < RD_PORTS; i++)
         begin
            rd_s1_q[i]       <= rd_pin[i];
            rd_s2_q[i]       <= rd_s1_q[i];
            rd_clk_prev_q[i] <= rd_s2_q[i].clk;
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wr_s1_q       <= '0;
         wr_s2_q       <= '0;
         wr_clk_prev_q <= 1'b0;
      end
      else
      begin
         wr_s1_q       <= wr_in;
         wr_s2_q       <= wr_s1_q;
         wr_clk_prev_q <= wr_s2_q.clk;
      end
   end

   // Static settings are tied, but still pass two flops as pins
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cfg_s1_q <= '0;
         cfg_s2_q <= '0;
      end
      else
      begin
         cfg_s1_q <= cfg;
         cfg_s2_q <= cfg_s1_q;
      end
   end

   always_comb
   begin
      for (int i = 0; i < RD_PORTS; i++)
      begin
         rd_tick[i] = rd_s2_q[i].clk & ~rd_clk_prev_q[i];
      end
   end

   assign wr_tick = wr_s2_q.clk & ~wr_clk_prev_q;

   // =========================================================
   // Write command capture, triplicated for transient hardening
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int k = 0; k < VOTE_N; k++)
         begin
            wr_cmd_q[k] <= '0;
         end
      end
      else
      begin
         for (int k = 0; k < VOTE_N; k++)
         begin
            // Inputs captured on the write clock edge
            wr_cmd_q[k].go   <= wr_tick && (wr_s2_q.select == SEL_ALL)
                                && wr_s2_q.wen;
            wr_cmd_q[k].wide <= (cfg_s2_q.wr_width == WIDTH_WIDE);
            if (wr_tick)
            begin
               wr_cmd_q[k].addr <= wr_s2_q.addr;
               wr_cmd_q[k].din  <= wr_s2_q.din;
            end
         end
      end
   end

   // Majority of three copies when hardening is on, first copy otherwise
   always_comb
   begin
      wr_cmd = wr_cmd_q[0];
      if (cfg_s2_q.transient_harden_enable)
      begin
         wr_cmd.go   = tpr_vote(wr_cmd_q[0].go, wr_cmd_q[1].go,
                                wr_cmd_q[2].go);
         wr_cmd.wide = tpr_vote(wr_cmd_q[0].wide, wr_cmd_q[1].wide,
                                wr_cmd_q[2].wide);
         for (int b = 0; b < ADDR_W; b++)
         begin
            wr_cmd.addr[b] = tpr_vote(wr_cmd_q[0].addr[b], wr_cmd_q[1].addr[b],
                                      wr_cmd_q[2].addr[b]);
         end
         for (int b = 0; b < DATA_W; b++)
         begin
            wr_cmd.din[b] = tpr_vote(wr_cmd_q[0].din[b], wr_cmd_q[1].din[b],
                                     wr_cmd_q[2].din[b]);
         end
      end
   end

   assign wr_chk = tpr_ecc_check(wr_cmd.din);

   // =========================================================
   // Internal system interface
   assign sys_take    = sys_in.req && !cfg_s2_q.system_access_lock;
   assign sys_rd_take = sys_take && !sys_in.we;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         busy_q      <= 1'b0;
         sys_rdata_q <= '0;
      end
      else
      begin
         busy_q <= sys_take;
         if (sys_rd_take)
         begin
            sys_rdata_q <= mem[sys_in.addr];
         end
      end
   end

   // =========================================================
   // Storage array; the port write wins over a system write
   always_ff @(posedge clk)
   begin
      if (wr_cmd.go)
      begin
         if (wr_cmd.wide)
         begin
            // Wide words span an even and odd entry, bit zero ignored
            mem[{wr_cmd.addr[ADDR_W-1:1], HALF_LOW}][NARROW_W-1:0]
               <= wr_cmd.din[NARROW_W-1:0];
            mem[{wr_cmd.addr[ADDR_W-1:1], HALF_HIGH}][NARROW_W-1:0]
               <= wr_cmd.din[DATA_W-1:NARROW_W];
            if (cfg_s2_q.ecc_enable)
            begin
               mem[{wr_cmd.addr[ADDR_W-1:1], HALF_LOW}][ENTRY_W-1:NARROW_W]
                  <= wr_chk[CHK_HALF-1:0];
               mem[{wr_cmd.addr[ADDR_W-1:1], HALF_HIGH}][ENTRY_W-1:NARROW_W]
                  <= wr_chk[CHK_W-1:CHK_HALF];
            end
         end
         else if (cfg_s2_q.twelve_bit_mode)
         begin
            mem[wr_cmd.addr] <= wr_cmd.din[ENTRY_W-1:0];
         end
         else
         begin
            mem[wr_cmd.addr][NARROW_W-1:0] <= wr_cmd.din[NARROW_W-1:0];
         end
      end
      else if (sys_take && sys_in.we)
      begin
         mem[sys_in.addr] <= sys_in.wdata;
      end
   end

   // =========================================================
   // Read ports
   for (genvar i = 0; i < RD_PORTS; i++)
   begin : g_rd
      logic [SEL_W+ADDR_W-1:0] addr_d;
      logic [SEL_W+ADDR_W-1:0] addr_q;
      logic [ADDR_W-1:0]       raddr;
      logic                    rsel;
      logic                    wide;
      logic                    a_bypass;
      logic                    p_bypass;
      logic [ENTRY_W-1:0]      lo_entry;
      logic [ENTRY_W-1:0]      hi_entry;
      tpr_rd_out_t             raw;
      tpr_rd_out_t             fixed;
      tpr_rd_out_t             ecc_pipe_q;
      tpr_rd_out_t             ecc_out;
      tpr_rd_out_t             pipe_q;
      logic                    ecc_on;

      assign wide     = (i == 0) ? cfg_s2_q.rd0_width : cfg_s2_q.rd1_width;
      assign a_bypass = (i == 0) ? cfg_s2_q.rd0_addr_bypass : cfg_s2_q.rd1_addr_bypass;
      assign p_bypass = (i == 0) ? cfg_s2_q.rd0_pipe_bypass : cfg_s2_q.rd1_pipe_bypass;
      assign ecc_on   = cfg_s2_q.ecc_enable && (wide == WIDTH_WIDE);
      assign addr_d   = {rd_s2_q[i].select, rd_s2_q[i].addr};

      tpr_rd_reg #(
         .W (SEL_W + ADDR_W)
      ) u_addr_reg (
         .clk          (clk),
         .arst         (rd_arst),
         .tick         (rd_tick[i]),
         .bypass       (a_bypass),
         .en           (rd_s2_q[i].addr_en),
         .sync_clear_n (rd_s2_q[i].addr_sync_clear_n),
         .d            (addr_d),
         .q            (addr_q)
      );

      assign raddr    = addr_q[ADDR_W-1:0];
      assign rsel     = (addr_q[SEL_W+ADDR_W-1:ADDR_W] == SEL_ALL);
      // Both ports read the array freely, also at one address
      assign lo_entry = mem[{raddr[ADDR_W-1:1], HALF_LOW}];
      assign hi_entry = mem[{raddr[ADDR_W-1:1], HALF_HIGH}];

      always_comb
      begin
         raw = '0;
         if (!rsel)
         begin
            raw = '0;
         end
         else if (wide == WIDTH_WIDE)
         begin
            raw.data = {hi_entry[NARROW_W-1:0], lo_entry[NARROW_W-1:0]};
         end
         else if (cfg_s2_q.twelve_bit_mode)
         begin
            raw.data = {{(DATA_W-ENTRY_W){1'b0}}, mem[raddr]};
         end
         else
         begin
            raw.data = {{(DATA_W-NARROW_W){1'b0}}, mem[raddr][NARROW_W-1:0]};
         end
      end

      always_comb
      begin
         fixed = raw;
         if (ecc_on && rsel)
         begin
            fixed = tpr_ecc_fix(raw.data, {hi_entry[ENTRY_W-1:NARROW_W],
                                           lo_entry[ENTRY_W-1:NARROW_W]});
         end
      end

      // Extra correction stage on the port clock when not skipped
      always_ff @(posedge clk or posedge rd_arst)
      begin
         if (rd_arst)
         begin
            ecc_pipe_q <= '0;
         end
         else if (rd_tick[i])
         begin
            ecc_pipe_q <= fixed;
         end
      end

      assign ecc_out = (ecc_on && !cfg_s2_q.correction_pipe_skip) ? ecc_pipe_q : fixed;

      tpr_rd_reg #(
         .W ($bits(tpr_rd_out_t))
      ) u_pipe_reg (
         .clk          (clk),
         .arst         (rd_arst),
         .tick         (rd_tick[i]),
         .bypass       (p_bypass),
         .en           (rd_s2_q[i].pipe_en),
         .sync_clear_n (rd_s2_q[i].pipe_sync_clear_n),
         .d            (ecc_out),
         .q            (pipe_q)
      );

      // Output flop: flags carry the double and single results
      always_ff @(posedge clk or posedge rd_arst)
      begin
         if (rd_arst)
         begin
            out_q[i] <= '0;
         end
         else
         begin
            out_q[i] <= pipe_q;
         end
      end
   end : g_rd

   // =========================================================
   // Outputs
   assign rd0_out   = out_q[0];
   assign rd1_out   = out_q[1];
   assign sys_rdata = sys_rdata_q;
   assign busy      = busy_q;

endmodule : tpr_three_port_mem

// >>> tb/tpr_mem_chk.sv
// Port-level assertions of the three-port memory.
// Assumes it is bound to tpr_three_port_mem and sees only its ports.
`timescale 1ns/1ps

module tpr_mem_chk
   import tpr_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        global_async_clear_n,
   input wire tpr_rd_in_t  rd1_in,
   input wire tpr_cfg_t    cfg,
   input wire tpr_sys_in_t sys_in,
   input wire tpr_rd_out_t rd0_out,
   input wire tpr_rd_out_t rd1_out,
   input wire logic        busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // ==========================================================
   // Read side
   property p_clear_empties;
      !global_async_clear_n |-> rd0_out == '0 && rd1_out == '0;
   endproperty
   a_clear_empties: assert property (p_clear_empties)
      else $error("read outputs not cleared");

   property p_desel_zero;
      (cfg.rd1_addr_bypass && rd1_in.select != SEL_ALL) [*6] |-> rd1_out == '0;
   endproperty
   a_desel_zero: assert property (p_desel_zero)
      else $error("deselected port not zero");

   property p_narrow_upper;
      !cfg.rd1_width && !cfg.twelve_bit_mode |-> rd1_out.data[DATA_W-1:NARROW_W] == '0;
   endproperty
   a_narrow_upper: assert property (p_narrow_upper)
      else $error("narrow read upper bits set");

   property p_single_off;
      !cfg.ecc_enable [*4] |-> !rd0_out.single_fixed && !rd1_out.single_fixed;
   endproperty
   a_single_off: assert property (p_single_off)
      else $error("single flag without correction");

   property p_double_off;
      !cfg.ecc_enable [*4] |-> !rd0_out.double_found && !rd1_out.double_found;
   endproperty
   a_double_off: assert property (p_double_off)
      else $error("double flag without correction");

   // ==========================================================
   // System access
   property p_busy_cause;
      busy |-> $past(sys_in.req) && !$past(cfg.system_access_lock);
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy without accepted access");

   property p_req_busy;
      sys_in.req && !cfg.system_access_lock |=> busy;
   endproperty
   a_req_busy: assert property (p_req_busy)
      else $error("access without busy");

   property p_lock_blocks;
      sys_in.req && cfg.system_access_lock |=> !busy;
   endproperty
   a_lock_blocks: assert property (p_lock_blocks)
      else $error("locked access went through");
endmodule : tpr_mem_chk

bind tpr_three_port_mem tpr_mem_chk tpr_mem_chk_inst (
   .clk                  (clk),
   .reset                (reset),
   .global_async_clear_n (global_async_clear_n),
   .rd1_in               (rd1_in),
   .cfg                  (cfg),
   .sys_in               (sys_in),
   .rd0_out              (rd0_out),
   .rd1_out              (rd1_out),
   .busy                 (busy)
);

// >>> tb/tpr_fab.sv
// Fabric-side model driving the read and write port pins.
// Assumes port clocks are slow against clk, as the design samples them.
`timescale 1ns/1ps

module tpr_fab
   import tpr_pkg::*;
(
   input  wire logic clk,
   output tpr_rd_in_t rd0_in,
   output tpr_rd_in_t rd1_in,
   output tpr_wr_in_t wr_in
);
   initial
   begin
      // Selected, enabled, no clears
      rd0_in = 14'h003F;
      rd1_in = 14'h003F;
      wr_in  = '0;
   end

   task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                             input logic [SEL_W-1:0] s, input logic w);
      @(posedge clk);
      wr_in.addr   <= a;
      wr_in.din    <= d;
      wr_in.select <= s;
      wr_in.wen    <= w;
      repeat (4) @(posedge clk);
      wr_in.clk <= 1'b1;
      repeat (3) @(posedge clk);
      wr_in.clk <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : write_word

   task automatic set_rd(input logic p, input logic [ADDR_W-1:0] a,
                         input logic [SEL_W-1:0] s);
      @(posedge clk);
      if (p)
      begin
         rd1_in.addr   <= a;
         rd1_in.select <= s;
      end
      else
      begin
         rd0_in.addr   <= a;
         rd0_in.select <= s;
      end
   endtask : set_rd

   task automatic rd0_tick(input logic en, input logic clr_n);
      @(posedge clk);
      rd0_in.addr_en           <= en;
      rd0_in.addr_sync_clear_n <= clr_n;
      repeat (4) @(posedge clk);
      rd0_in.clk <= 1'b1;
      repeat (3) @(posedge clk);
      rd0_in.clk               <= 1'b0;
      rd0_in.addr_en           <= 1'b1;
      rd0_in.addr_sync_clear_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : rd0_tick
endmodule : tpr_fab

// >>> tb/test_three_port_ecc_ram.sv
// Self-checking bench of the three-port memory with its fabric model.
// Assumes the package, checker and fabric model are compiled first.
`timescale 1ns/1ps

`define CHK(got, want) \
   begin \
      compares++; \
      if ((got) !== (want)) \
      begin \
         fails++; \
         $display("unexpected at %0t: got %h want %h", $time, got, want); \
      end \
   end

module test_three_port_ecc_ram
   import tpr_pkg::*;
;
   logic               clk;
   logic               reset;
   logic               clear_n;
   tpr_cfg_t           cfg;
   tpr_sys_in_t        sys_in;
   tpr_rd_in_t         rd0_in;
   tpr_rd_in_t         rd1_in;
   tpr_wr_in_t         wr_in;
   tpr_rd_out_t        rd0_out;
   tpr_rd_out_t        rd1_out;
   logic [ENTRY_W-1:0] sys_rdata;
   logic               busy;
   int                 fails = 0;
   int                 compares = 0;
   int                 cycles = 0;

   tpr_three_port_mem tpr_three_port_mem_inst (
      .clk                  (clk),
      .reset                (reset),
      .global_async_clear_n (clear_n),
      .rd0_in               (rd0_in),
      .rd1_in               (rd1_in),
      .wr_in                (wr_in),
      .cfg                  (cfg),
      .sys_in               (sys_in),
      .rd0_out              (rd0_out),
      .rd1_out              (rd1_out),
      .sys_rdata            (sys_rdata),
      .busy                 (busy)
   );

   tpr_fab tpr_fab_inst (
      .clk    (clk),
      .rd0_in (rd0_in),
      .rd1_in (rd1_in),
      .wr_in  (wr_in)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask : settle

   task automatic t_write_read();
      tpr_fab_inst.write_word(7'h00, 18'h00000, SEL_ALL, 1'b1);
      tpr_fab_inst.write_word(7'h10, 18'h2B5A3, SEL_ALL, 1'b1);
      tpr_fab_inst.set_rd(1'b1, 7'h10, SEL_ALL);
      tpr_fab_inst.set_rd(1'b0, 7'h10, SEL_ALL);
      tpr_fab_inst.rd0_tick(1'b1, 1'b1);
      settle();
      `CHK(rd0_out.data, 18'h2B5A3)
      `CHK(rd1_out.data, 18'h001A3)
      tpr_fab_inst.set_rd(1'b1, 7'h11, SEL_ALL);
      settle();
      `CHK(rd1_out.data, 18'h0015A)
      $display("test done: write and read");
   endtask : t_write_read

   task automatic t_write_refused();
      logic [SEL_W-1:0] sels [3] = '{2'h1, 2'h2, SEL_ALL};
      logic             wens [3] = '{1'b1, 1'b1, 1'b0};
      tpr_fab_inst.write_word(7'h20, 18'h1E4C7, SEL_ALL, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         tpr_fab_inst.write_word(7'h20, 18'h3FFFF, sels[i], wens[i]);
      end
      tpr_fab_inst.set_rd(1'b0, 7'h20, SEL_ALL);
      tpr_fab_inst.rd0_tick(1'b1, 1'b1);
      settle();
      `CHK(rd0_out.data, 18'h1E4C7)
      tpr_fab_inst.write_word(7'h20, 18'h12345, SEL_ALL, 1'b1);
      settle();
      `CHK(rd0_out.data, 18'h12345)
      $display("test done: refused writes");
   endtask : t_write_refused

   task automatic t_addr_reg();
      tpr_fab_inst.set_rd(1'b0, 7'h10, SEL_ALL);
      tpr_fab_inst.rd0_tick(1'b0, 1'b1);
      settle();
      `CHK(rd0_out.data, 18'h12345)
      tpr_fab_inst.rd0_tick(1'b1, 1'b0);
      settle();
      `CHK(rd0_out.data, 18'h00000)
      tpr_fab_inst.rd0_tick(1'b1, 1'b1);
      settle();
      `CHK(rd0_out.data, 18'h2B5A3)
      $display("test done: address register");
   endtask : t_addr_reg

   task automatic t_deselect();
      for (int i = 0; i < 3; i++)
      begin
         tpr_fab_inst.set_rd(1'b1, 7'h10, 2'(i));
         settle();
         `CHK(rd1_out, tpr_rd_out_t'(0))
      end
      tpr_fab_inst.set_rd(1'b0, 7'h10, 2'h1);
      tpr_fab_inst.rd0_tick(1'b1, 1'b1);
      settle();
      `CHK(rd0_out, tpr_rd_out_t'(0))
      $display("test done: deselect");
   endtask : t_deselect

   task automatic t_global_clear();
      tpr_fab_inst.set_rd(1'b1, 7'h10, SEL_ALL);
      tpr_fab_inst.set_rd(1'b0, 7'h10, SEL_ALL);
      tpr_fab_inst.rd0_tick(1'b1, 1'b1);
      settle();
      @(posedge clk);
      clear_n <= 1'b0;
      #1;
      `CHK(rd0_out, tpr_rd_out_t'(0))
      `CHK(rd1_out, tpr_rd_out_t'(0))
      repeat (3) @(posedge clk);
      clear_n <= 1'b1;
      settle();
      `CHK(rd1_out.data, 18'h001A3)
      tpr_fab_inst.rd0_tick(1'b1, 1'b1);
      settle();
      `CHK(rd0_out.data, 18'h2B5A3)
      $display("test done: global clear");
   endtask : t_global_clear

   task automatic restart(input tpr_cfg_t c);
      @(posedge clk);
      reset <= 1'b1;
      cfg   <= c;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : restart

   task automatic sys_op(input logic w, input logic [ENTRY_W-1:0] wd);
      @(posedge clk);
      sys_in <= '{req: 1'b1, we: w, addr: 7'h10, wdata: wd};
      @(posedge clk);
      sys_in.req <= 1'b0;
      #1;
   endtask : sys_op

   task automatic t_ecc_lock();
      logic [ENTRY_W-1:0] e;
      // All ports wide with correction, direct mode
      restart(12'hE7E);
      tpr_fab_inst.write_word(7'h10, 18'h0F0F0, SEL_ALL, 1'b1);
      settle();
      `CHK(rd1_out, 20'h0F0F0)
      sys_op(1'b0, '0);
      e = sys_rdata;
      sys_op(1'b1, e ^ 12'h001);
      settle();
      `CHK(rd1_out, 20'h4F0F0)
      sys_op(1'b1, e ^ 12'h003);
      settle();
      `CHK(rd1_out.double_found, 1'b1)
      restart(12'hE7F);
      sys_op(1'b1, e);
      `CHK(busy, 1'b0)
      settle();
      `CHK(rd1_out.double_found, 1'b1)
      $display("test done: correction and lock");
   endtask : t_ecc_lock

   task automatic t_system();
      sys_op(1'b0, '0);
      `CHK(busy, 1'b1)
      `CHK(sys_rdata[8:0], 9'h1A3)
      @(posedge clk);
      #1;
      `CHK(busy, 1'b0)
      $display("test done: system access");
   endtask : t_system

   initial
   begin
      reset   = 1'b1;
      clear_n = 1'b1;
      // rd0 wide with address register, rd1 narrow transparent, wr wide, no correction
      cfg     = 12'hA76;
      sys_in  = '0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      t_write_read();
      t_write_refused();
      t_addr_reg();
      t_deselect();
      t_global_clear();
      t_system();
      t_ecc_lock();
      give_verdict();
   end
endmodule : test_three_port_ecc_ram
